// ==== design/matrix_bit_ops_unit.sv ====
// Matrix bit operation unit with APB registers and word memory.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module matrix_bit_ops_unit #(
    parameter int DEPTH = 1024,
    parameter int SCAN_DIV = mbit_pkg::SCAN_DIV_DEF
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [mbit_pkg::APB_AW-1:0] PADDR,
    input wire logic [mbit_pkg::DATA_W-1:0] PWDATA,
    output logic [mbit_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Interrupt
    output logic IRQ
);
    import mbit_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [16:0] LAST_WORD = 17'(DEPTH - 1);
    localparam logic [15:0] DIV_LAST = 16'(SCAN_DIV - 1);

    // Word memory; every datapath word is 16 bits wide.
    logic [WORD_W-1:0] mem [DEPTH];

    logic [2:0] ctrl_op;
    logic ctrl_pulse, ctrl_en;
    logic cfg_inc, cfg_clr, cfg_borrow, cfg_csel;
    logic [15:0] src, dst, len, ptr, err_code, mem_addr;
    logic carry, end_flag, perr, gerr, czero;
    logic [IRQ_W-1:0] irq_stat, irq_mask, ev;
    state_type state;
    logic [7:0] idx;
    logic [15:0] cnt;
    logic [15:0] div_cnt;
    logic scan_tick, en_rise, start, busy;
    logic pready_q, acc, wr, rd_done, mem_sel, hit;
    logic [31:0] rdata, next_rdata;
    logic [15:0] eff_ptr, bit_lim, rd_sum, wr_sum, rd_word, next_err;
    logic [15:0] word_cnt, next_cnt;
    logic [4:0] ones;
    logic [16:0] src_end, dst_end;
    logic ptr_ok, ptr_last, is_bit, sel_bit, len_ok, src_ok, dst_ok;
    logic dst_one, last_idx, op_ok, looping;

    function automatic logic [4:0] ones_in(input logic [15:0] w);
        logic [4:0] s;
        s = 5'h00;
        for (int i = 0; i < WORD_W; i++) begin
            s = s + {4'h0, w[i]};
        end
        return s;
    endfunction : ones_in

    // Scan rate divider.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            div_cnt <= 16'h0000;
            scan_tick <= 1'b0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= 16'h0000;
            scan_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            scan_tick <= 1'b0;
        end
    end

    scan_edge u_edge (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .sample(scan_tick),
        .level(ctrl_en),
        .rise(en_rise)
    );

    assign busy = state != ST_IDLE;
    // A busy engine skips the scan; pulse mode waits for a fresh edge.
    assign start = scan_tick & ~busy & (ctrl_pulse ? en_rise : ctrl_en);

    // APB access decode; one wait state, more while memory is busy.
    assign mem_sel = PADDR == MEM_DATA_OFS;
    assign acc = PSEL & PENABLE & pready_q;
    assign wr = acc & PWRITE;
    assign rd_done = acc & ~PWRITE;
    assign PREADY = pready_q;
    assign PSLVERR = pready_q & ~hit;
    assign PRDATA = rdata;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= PSEL & PENABLE & ~pready_q & ~(busy & mem_sel);
        end
    end

    always_comb begin
        next_rdata = 32'h00000000;
        hit = 1'b1;
        case (PADDR)
            CTRL_OFS: next_rdata = {27'h0, ctrl_en, ctrl_pulse, ctrl_op};
            CFG_OFS: next_rdata = {28'h0, cfg_csel, cfg_borrow, cfg_clr,
                                   cfg_inc};
            SRC_OFS: next_rdata = {16'h0000, src};
            DST_OFS: next_rdata = {16'h0000, dst};
            LEN_OFS: next_rdata = {16'h0000, len};
            PTR_OFS: next_rdata = {16'h0000, ptr};
            FLAGS_OFS: next_rdata = {26'h0, busy, czero, gerr, perr,
                                     end_flag, carry};
            ERR_OFS: next_rdata = {16'h0000, err_code};
            IRQ_STAT_OFS: next_rdata = {28'h0, irq_stat};
            IRQ_MASK_OFS: next_rdata = {28'h0, irq_mask};
            MEM_ADDR_OFS: next_rdata = {16'h0000, mem_addr};
            MEM_DATA_OFS: next_rdata = {16'h0000, mem[mem_addr[AW-1:0]]};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rdata <= 32'h00000000;
        end else if (PSEL && PENABLE && !pready_q) begin
            rdata <= PWRITE ? 32'h00000000 : next_rdata;
        end
    end

    // Software-written control registers.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ctrl_op <= 3'h0;
            ctrl_pulse <= 1'b0;
            ctrl_en <= 1'b0;
            {cfg_csel, cfg_borrow, cfg_clr, cfg_inc} <= 4'h0;
            src <= 16'h0000;
            dst <= 16'h0000;
            len <= 16'h0000;
            irq_mask <= 4'h0;
            mem_addr <= 16'h0000;
        end else if (wr) begin
            case (PADDR)
                CTRL_OFS: begin
                    ctrl_op <= PWDATA[CTRL_OP_MSB:CTRL_OP_LSB];
                    ctrl_pulse <= PWDATA[CTRL_PULSE_BIT];
                    ctrl_en <= PWDATA[CTRL_EN_BIT];
                end
                CFG_OFS: begin
                    cfg_inc <= PWDATA[CFG_INC_BIT];
                    cfg_clr <= PWDATA[CFG_CLR_BIT];
                    cfg_borrow <= PWDATA[CFG_BORROW_BIT];
                    cfg_csel <= PWDATA[CFG_CSEL_BIT];
                end
                SRC_OFS: src <= PWDATA[15:0];
                DST_OFS: dst <= PWDATA[15:0];
                LEN_OFS: len <= PWDATA[15:0];
                IRQ_MASK_OFS: irq_mask <= PWDATA[IRQ_W-1:0];
                MEM_ADDR_OFS: mem_addr <= PWDATA[15:0];
                default: ;
            endcase
        end
    end

    // Operand checks and datapath.
    assign eff_ptr = cfg_clr ? 16'h0000 : ptr;
    assign bit_lim = len << BIT_SHIFT;
    assign ptr_ok = eff_ptr < bit_lim;
    assign ptr_last = eff_ptr == bit_lim - 16'h0001;
    assign is_bit = ctrl_op == matrix_bit_read_op
                  || ctrl_op == matrix_bit_write_op;
    assign looping = ctrl_op == matrix_invert_op
                   || ctrl_op == matrix_bit_count_op;
    assign op_ok = ctrl_op <= magnitude_op;
    assign len_ok = len >= LEN_MIN && len <= LEN_MAX;
    assign src_end = {1'b0, src} + {1'b0, len} - 17'h00001;
    assign dst_end = {1'b0, dst} + {1'b0, len} - 17'h00001;
    assign src_ok = src_end <= LAST_WORD;
    assign dst_ok = dst_end <= LAST_WORD;
    assign dst_one = {1'b0, dst} <= LAST_WORD;
    assign last_idx = {8'h00, idx} == len - 16'h0001;

    always_comb begin
        if (is_bit) begin
            rd_sum = src + (eff_ptr >> BIT_SHIFT);
        end else if (ctrl_op == magnitude_op) begin
            rd_sum = dst;
        end else begin
            rd_sum = src + {8'h00, idx};
        end
    end

    assign wr_sum = dst + {8'h00, idx};
    assign rd_word = mem[rd_sum[AW-1:0]];
    assign sel_bit = rd_word[eff_ptr[BIT_SHIFT-1:0]];
    assign ones = ones_in(rd_word);
    assign word_cnt = cfg_csel ? {11'h000, ones}
                               : WORD_BITS - {11'h000, ones};
    assign next_cnt = cnt + word_cnt;

    always_comb begin
        next_err = ERR_NONE;
        if (ctrl_op == magnitude_op) begin
            if (!dst_one) next_err = ERR_RANGE;
        end else if (!len_ok) begin
            next_err = ERR_LEN;
        end else if (ctrl_op == matrix_invert_op && !(src_ok && dst_ok)) begin
            next_err = ERR_RANGE;
        end else if (!src_ok) begin
            next_err = ERR_RANGE;
        end else if (ctrl_op == matrix_bit_count_op && !dst_one) begin
            next_err = ERR_RANGE;
        end
    end

    // Operation sequencer.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            idx <= 8'h00;
            cnt <= 16'h0000;
        end else begin
            unique case (state)
                ST_IDLE: if (start) state <= ST_CHECK;
                ST_CHECK: begin
                    idx <= 8'h00;
                    cnt <= 16'h0000;
                    state <= (next_err != ERR_NONE || !op_ok) ? ST_DONE
                                                               : ST_RUN;
                end
                ST_RUN: begin
                    if (looping && !last_idx) begin
                        idx <= idx + 8'h01;
                        cnt <= next_cnt;
                    end else begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: state <= ST_IDLE;
            endcase
        end
    end

    // Memory writes; software access is stalled while the engine runs.
    always_ff @(posedge REF_CLK) begin
        if (state == ST_RUN) begin
            if (ctrl_op == matrix_invert_op) begin
                mem[wr_sum[AW-1:0]] <= ~rd_word;
            end else if (ctrl_op == matrix_bit_write_op && ptr_ok) begin
                mem[rd_sum[AW-1:0]][eff_ptr[BIT_SHIFT-1:0]] <= cfg_borrow;
            end else if (ctrl_op == magnitude_op && rd_word[WORD_W-1]) begin
                mem[rd_sum[AW-1:0]] <= 16'h0000 - rd_word;
            end else if (ctrl_op == matrix_bit_count_op && last_idx) begin
                mem[dst[AW-1:0]] <= next_cnt;
            end
        end else if (wr && mem_sel) begin
            mem[mem_addr[AW-1:0]] <= PWDATA[15:0];
        end
    end

    // Pointer word; the engine's update wins over a software write.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ptr <= 16'h0000;
        end else if (state == ST_RUN && is_bit) begin
            if (ptr_ok) begin
                ptr <= (ptr_last || !cfg_inc) ? eff_ptr
                                              : eff_ptr + 16'h0001;
            end
        end else if (wr && PADDR == PTR_OFS) begin
            ptr <= PWDATA[15:0];
        end
    end

    // Result flags and error code.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            carry <= 1'b0;
            end_flag <= 1'b0;
            perr <= 1'b0;
            czero <= 1'b0;
        end else if (state == ST_RUN) begin
            if (is_bit) begin
                perr <= ~ptr_ok;
                if (ptr_ok) begin
                    end_flag <= ptr_last;
                    if (ctrl_op == matrix_bit_read_op) carry <= sel_bit;
                end
            end else if (ctrl_op == matrix_bit_count_op && last_idx) begin
                czero <= next_cnt == 16'h0000;
            end
        end
    end

    // A new error wins over a software clear in the same cycle.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            gerr <= 1'b0;
            err_code <= ERR_NONE;
        end else if (state == ST_CHECK && next_err != ERR_NONE) begin
            gerr <= 1'b1;
            err_code <= next_err;
        end else if (wr && PADDR == FLAGS_OFS && PWDATA[FLG_GERR]) begin
            gerr <= 1'b0;
        end
    end

    // Interrupt status: a read clears only what it returned.
    always_comb begin
        ev = 4'h0;
        ev[IRQ_DONE] = state == ST_DONE;
        ev[IRQ_GERR] = state == ST_CHECK && next_err != ERR_NONE;
        ev[IRQ_PERR] = state == ST_RUN && is_bit && !ptr_ok;
        ev[IRQ_END] = state == ST_RUN && is_bit && ptr_ok && ptr_last;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            irq_stat <= 4'h0;
        end else if (rd_done && PADDR == IRQ_STAT_OFS) begin
            irq_stat <= (irq_stat & ~rdata[IRQ_W-1:0]) | ev;
        end else begin
            irq_stat <= irq_stat | ev;
        end
    end

    assign IRQ = |(irq_stat & irq_mask);

    // Helper that records each inverted word for checking.
    logic inv_chk;
    logic [AW-1:0] inv_addr;
    logic [15:0] inv_exp;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            inv_chk <= 1'b0;
            inv_addr <= '0;
            inv_exp <= 16'h0000;
        end else begin
            inv_chk <= state == ST_RUN && ctrl_op == matrix_invert_op;
            inv_addr <= wr_sum[AW-1:0];
            inv_exp <= ~rd_word;
        end
    end

    invert_word_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        inv_chk |-> mem[inv_addr] == inv_exp)
        else $error("inverted word not stored");

    len_error_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state == ST_CHECK && ctrl_op != magnitude_op && !len_ok
        |=> gerr && err_code == ERR_LEN && state == ST_DONE)
        else $error("bad length not flagged");

    inv_range_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state == ST_CHECK && ctrl_op == matrix_invert_op && len_ok
        && !dst_ok |=> err_code == ERR_RANGE && state == ST_DONE)
        else $error("invert range error missed");

    read_range_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state == ST_CHECK && ctrl_op == matrix_bit_read_op && len_ok
        && !src_ok |=> gerr ##1 state == ST_IDLE && err_code == ERR_RANGE)
        else $error("bit read range error missed");

    carry_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state == ST_RUN && ctrl_op == matrix_bit_read_op && ptr_ok
        |=> carry == $past(sel_bit))
        else $error("carry does not hold the read bit");

    ptr_step_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state == ST_RUN && is_bit && ptr_ok && !ptr_last && cfg_inc
        |=> ptr == $past(eff_ptr) + 16'h0001)
        else $error("pointer did not advance");

    end_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state == ST_RUN && is_bit && ptr_ok && ptr_last
        |=> end_flag && ptr == $past(eff_ptr) && irq_stat[IRQ_END])
        else $error("last bit not handled");

    ptr_error_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state == ST_RUN && is_bit && !ptr_ok
        |=> perr && $stable(carry) && $stable(ptr))
        else $error("pointer error not raised");

    pulse_once_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        ctrl_pulse && $rose(state == ST_CHECK) |-> $past(en_rise))
        else $error("pulse run without rising enable");
endmodule : matrix_bit_ops_unit

// ==== design/mbit_pkg.sv ====
// Shared constants and types for the matrix bit operation unit.
package mbit_pkg;
    localparam int APB_AW = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int BIT_SHIFT = 4;
    localparam logic [15:0] WORD_BITS = 16'h0010;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CFG_OFS = 8'h04;
    localparam logic [7:0] SRC_OFS = 8'h08;
    localparam logic [7:0] DST_OFS = 8'h0C;
    localparam logic [7:0] LEN_OFS = 8'h10;
    localparam logic [7:0] PTR_OFS = 8'h14;
    localparam logic [7:0] FLAGS_OFS = 8'h18;
    localparam logic [7:0] ERR_OFS = 8'h1C;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
    localparam logic [7:0] MEM_ADDR_OFS = 8'h28;
    localparam logic [7:0] MEM_DATA_OFS = 8'h2C;

    // Field positions.
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_OP_MSB = 2;
    localparam int CTRL_PULSE_BIT = 3;
    localparam int CTRL_EN_BIT = 4;
    localparam int CFG_INC_BIT = 0;
    localparam int CFG_CLR_BIT = 1;
    localparam int CFG_BORROW_BIT = 2;
    localparam int CFG_CSEL_BIT = 3;
    localparam int FLG_CARRY = 0;
    localparam int FLG_END = 1;
    localparam int FLG_PERR = 2;
    localparam int FLG_GERR = 3;
    localparam int FLG_CZERO = 4;
    localparam int FLG_BUSY = 5;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_GERR = 1;
    localparam int IRQ_PERR = 2;
    localparam int IRQ_END = 3;
    localparam int IRQ_W = 4;

    // Error codes and operand limits.
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_RANGE = 16'h2003;
    localparam logic [15:0] ERR_LEN = 16'h200B;
    localparam logic [15:0] LEN_MIN = 16'h0001;
    localparam logic [15:0] LEN_MAX = 16'h0100;

    // Scan period in clock cycles.
    localparam int SCAN_DIV_DEF = 100;

    typedef enum logic [2:0] {
        matrix_invert_op = 3'h0,
        matrix_bit_read_op = 3'h1,
        matrix_bit_write_op = 3'h2,
        matrix_bit_count_op = 3'h3,
        magnitude_op = 3'h4
    } op_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CHECK = 2'h1,
        ST_RUN = 2'h3,
        ST_DONE = 2'h2
    } state_type;
endpackage : mbit_pkg

// ==== design/scan_edge.sv ====
// Rising-edge detector of a level sampled once per scan.
`timescale 1ns/1ps
module scan_edge (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sampling
    input wire logic sample,
    input wire logic level,
    output logic rise
);
    logic prev;

    // The level is remembered only at scan boundaries, so a pulse
    // variant fires once per off-to-on change seen between scans.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else if (sample) begin
            prev <= level;
        end
    end

    assign rise = sample & level & ~prev;
endmodule : scan_edge

// ==== tb/apb_host.sv ====
// APB host model that issues one transfer at a time.
`timescale 1ns/1ps
module apb_host (
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Status
    output logic hung
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hung = 1'b0;
    end

    // The request is held until pready is seen high, however long the
    // slave stalls; only the bound on the wait ends it early.
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 600);
        if (pready !== 1'b1) hung <= 1'b1;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host

// ==== tb/matrix_bit_ops_unit_tb_top.sv ====
// Self-checking testbench of the matrix bit operation unit.
`timescale 1ns/1ps
module matrix_bit_ops_unit_tb_top;
    import mbit_pkg::*;
    localparam int DEPTH = 1024;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic hung;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int error_cnt = 0;
    int checks_done = 0;
    logic [15:0] src_w [3] = '{16'h1234, 16'h00FF, 16'hA5A5};
    logic [31:0] lens [3] = '{32'h0, 32'h101, 32'h100};
    logic [31:0] lstat [3] = '{32'h3, 32'h3, 32'h1};
    logic [2:0] rop [3] = '{3'h0, 3'h0, 3'h1};
    logic [31:0] rsrc [3] = '{DEPTH - 2, 0, DEPTH - 2};
    logic [31:0] rdst [3] = '{16, DEPTH - 2, 16};
    logic [31:0] rptr [3] = '{32'd46, 32'd47, 32'd47};
    logic [31:0] rflg [3] = '{32'h0, 32'h1, 32'h2};

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    matrix_bit_ops_unit #(.DEPTH(DEPTH), .SCAN_DIV(4)) u_matrix_bit_ops_unit (
        .REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));

    apb_host u_apb_host (.clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hung(hung));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge hung) begin
        error_cnt++;
        end_sim();
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic e;
        u_apb_host.xfer(1'b1, a, d, v, e);
    endtask : wr

    task automatic creg(input string what, input logic [7:0] a,
        input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] v;
        logic e;
        u_apb_host.xfer(1'b0, a, 32'h0, v, e);
        chk(what, v & m, exp);
    endtask : creg

    task automatic mw(input logic [31:0] i, input logic [15:0] d);
        wr(MEM_ADDR_OFS, i);
        wr(MEM_DATA_OFS, {16'h0, d});
    endtask : mw

    task automatic mc(input string what, input logic [31:0] i,
        input logic [31:0] exp);
        wr(MEM_ADDR_OFS, i);
        creg(what, MEM_DATA_OFS, exp, 32'hFFFFFFFF);
    endtask : mc

    // Enable is dropped across a scan tick first, so the pulse form sees
    // a fresh rising enable; it then must run once and stay quiet.
    task automatic run(input logic [2:0] op, input logic [31:0] st);
        int n;
        wr(CTRL_OFS, {29'h0, op});
        repeat (10) @(posedge ref_clk);
        wr(CTRL_OFS, {27'h0, 2'b11, op});
        n = 0;
        while (irq !== 1'b1 && n < 600) begin
            @(posedge ref_clk);
            n++;
        end
        if (irq !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
        creg("irq_stat", IRQ_STAT_OFS, st, 32'hF);
        repeat (20) @(posedge ref_clk);
        chk("irq_once", {31'h0, irq}, 32'h0);
    endtask : run

    initial begin
        logic [31:0] v;
        logic e;
        rst_n = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        creg("flags_rst", FLAGS_OFS, 32'h0, 32'hFFFFFFFF);
        creg("err_rst", ERR_OFS, 32'h0, 32'hFFFFFFFF);
        u_apb_host.xfer(1'b0, 8'h40, 32'h0, v, e);
        chk("unmapped", {31'h0, e}, 32'h1);
        wr(IRQ_MASK_OFS, 32'h1);
        creg("mask", IRQ_MASK_OFS, 32'h1, 32'hFFFFFFFF);
        $display("test reset done");

        for (int i = 0; i < 3; i++) mw(i, src_w[i]);
        mw(19, 16'h5555);
        wr(SRC_OFS, 0);
        wr(DST_OFS, 16);
        wr(LEN_OFS, 3);
        run(3'h0, 32'h1);
        for (int i = 0; i < 3; i++) mc("inv", 16 + i, {16'h0, ~src_w[i]});
        mc("inv_end", 19, 32'h5555);
        $display("test invert done");
        // Memory has no reset, so every word that the full-length run
        // reads is written first; an unknown word would trip the checks.
        for (int i = 0; i < 256; i++) mw(i, 16'(i));

        for (int i = 0; i < 3; i++) begin
            wr(LEN_OFS, lens[i]);
            run(3'h0, lstat[i]);
            creg("len_flag", FLAGS_OFS, {lstat[i][1], 3'h0}, 32'h8);
            wr(FLAGS_OFS, 32'h8);
        end
        creg("len_code", ERR_OFS, {16'h0, ERR_LEN}, 32'hFFFFFFFF);
        wr(LEN_OFS, 3);
        for (int i = 0; i < 3; i++) begin
            wr(SRC_OFS, rsrc[i]);
            wr(DST_OFS, rdst[i]);
            run(rop[i], 32'h3);
            creg("rng_flag", FLAGS_OFS, 32'h8, 32'h8);
            creg("rng_code", ERR_OFS, {16'h0, ERR_RANGE}, 32'hFFFF);
            wr(FLAGS_OFS, 32'h8);
        end
        $display("test errors done");

        wr(SRC_OFS, 0);
        mw(0, 16'h0001);
        mw(2, 16'h4000);
        wr(CFG_OFS, 32'h1);
        wr(PTR_OFS, 45);
        for (int i = 0; i < 3; i++) begin
            run(3'h1, (i == 2) ? 32'h9 : 32'h1);
            creg("rd_ptr", PTR_OFS, rptr[i], 32'hFFFF);
            creg("rd_flag", FLAGS_OFS, rflg[i], 32'h7);
        end
        wr(CFG_OFS, 32'h3);
        wr(PTR_OFS, 30);
        run(3'h1, 32'h1);
        creg("clr_ptr", PTR_OFS, 32'h1, 32'hFFFF);
        creg("clr_flag", FLAGS_OFS, 32'h1, 32'h7);
        wr(CFG_OFS, 32'h1);
        wr(PTR_OFS, 48);
        run(3'h1, 32'h5);
        creg("oor_ptr", PTR_OFS, 32'd48, 32'hFFFF);
        creg("oor_flag", FLAGS_OFS, 32'h5, 32'h7);
        $display("test bit read done");

        wr(CFG_OFS, 32'h5);
        wr(PTR_OFS, 5);
        run(3'h2, 32'h1);
        creg("wr_ptr", PTR_OFS, 32'd6, 32'hFFFF);
        mc("wr_bit", 0, 32'h0021);
        creg("wr_flag", FLAGS_OFS, 32'h1, 32'h7);
        wr(PTR_OFS, 47);
        run(3'h2, 32'h9);
        creg("wr_end_ptr", PTR_OFS, 32'd47, 32'hFFFF);
        mc("wr_end_bit", 2, 32'hC000);
        creg("wr_end_flag", FLAGS_OFS, 32'h3, 32'h7);
        $display("test bit write done");

        wr(CFG_OFS, 32'h8);
        wr(LEN_OFS, 1);
        wr(DST_OFS, 20);
        run(3'h3, 32'h1);
        mc("count", 20, 32'h2);
        wr(CFG_OFS, 32'h0);
        run(3'h3, 32'h1);
        mc("count_zeros", 20, 32'hE);
        mw(0, 16'hFFFF);
        run(3'h3, 32'h1);
        creg("count_zero_flag", FLAGS_OFS, 32'h10, 32'h10);
        mw(16, 16'hFB2E);
        wr(DST_OFS, 16);
        run(3'h4, 32'h1);
        mc("magnitude", 16, 32'h04D2);
        // Level mode reruns on every scan, unlike the pulse form.
        wr(CTRL_OFS, 32'h14);
        repeat (20) @(posedge ref_clk);
        chk("irq_level", {31'h0, irq}, 32'h1);
        creg("level_stat", IRQ_STAT_OFS, 32'h1, 32'h1);
        repeat (20) @(posedge ref_clk);
        chk("irq_again", {31'h0, irq}, 32'h1);
        wr(CTRL_OFS, 32'h4);
        repeat (10) @(posedge ref_clk);
        u_apb_host.xfer(1'b0, IRQ_STAT_OFS, 32'h0, v, e);
        mc("mag_positive", 16, 32'h04D2);
        for (int i = 5; i < 8; i++) run(i[2:0], 32'h1);
        $display("test other ops done");
        end_sim();
    end
endmodule : matrix_bit_ops_unit_tb_top
